//--- core/fcl_device_end.sv
// Responding (managed) switch end: parses commit and connectivity check
// requests, answers with accept or reject, and holds the zoning policy.
// Assumes the requester keeps frame addressing stable for a whole frame.
`timescale 1ns/1ns
module fcl_device_end #(
  parameter int MAX_WORDS = 20
) (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  fcl_link_if.dev_mp                       link,
  input  wire logic                        policyLoad,
  input  wire logic [31:0]                 policyWord,
  input  wire logic                        commitEnable,
  input  wire logic                        checkEnable,
  input  wire fcl_pkg::fcl_link_params_type localParams,
  input  wire logic                        dbEqual,
  input  wire logic                        dbMergeable,
  input  wire logic                        bothDefaultZone,
  output logic [31:0]                      activePolicy,
  output logic                             strictMerge,
  output logic                             blockDefaultZone,
  output logic                             joinAdmit,
  output logic                             trafficAllow,
  output logic                             commitApplied,
  output logic                             checkAccepted,
  output logic [63:0]                      peerPortName,
  output logic [63:0]                      peerSwitchName
);

  // Counter holds a whole check frame; longer would need a wider count
  if (MAX_WORDS < 20 || MAX_WORDS > 31) begin : gen_words_check
    $error("fcl_device_end: MAX_WORDS must lie in 20..31");
  end

  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_RECV = 3'b010,
    DS_SEND = 3'b100
  } fcl_dev_state_type;

  typedef struct packed {
    fcl_dev_state_type     state;
    logic                  rqReady;
    logic [4:0]            cnt;
    logic [31:0]           cmd;
    logic                  addrOk;
    logic [23:0]           sid;
    logic [23:0]           did;
    logic [63:0]           port;
    logic [63:0]           sw;
    fcl_pkg::fcl_frame_type kind;
    logic [31:0]           lead;
    logic [4:0]            idx;
    logic [31:0]           data;
    logic                  valid;
    logic                  last;
    logic [31:0]           pending;
    logic [31:0]           policy;
    logic                  admit;
    logic                  allow;
    logic                  applied;
    logic                  checked;
    logic [63:0]           peerPort;
    logic [63:0]           peerSw;
  } fcl_dev_reg_type;

  fcl_dev_reg_type st;
  fcl_dev_reg_type next_st;

  // Next state: receive a request frame, decide, then send the reply
  always_comb begin
    logic       take;
    logic [4:0] words;
    logic       isCommit;
    logic       isCheck;
    logic       okCommit;
    logic       okCheck;
    logic [31:0] cmdNow;
    logic       addrNow;
    take     = link.reqValid && st.rqReady;
    words    = st.cnt + 5'h01;
    cmdNow   = (st.cnt == 5'h00) ? link.reqData : st.cmd;
    addrNow  = (st.cnt == 5'h00) ? 1'b1 : st.addrOk;
    isCommit = cmdNow == fcl_pkg::COMMIT_REQ_WORD;
    isCheck  = cmdNow == fcl_pkg::CHECK_REQ_WORD;
    okCommit = 1'b0;
    okCheck  = 1'b0;
    next_st  = st;
    next_st.applied = 1'b0;
    next_st.checked = 1'b0;

    // Policy staging; reserved bits are dropped on load
    if (policyLoad) begin
      next_st.pending = fcl_pkg::fcl_policy_clean(policyWord);
    end

    // Merge admission and default-zone traffic follow the active flags
    next_st.admit = st.policy[fcl_pkg::STRICT_MERGE_BIT] ? dbEqual
                                                         : dbMergeable;
    next_st.allow = !(st.policy[fcl_pkg::DEFAULT_ZONE_BIT]
                      && bothDefaultZone);

    case (st.state)
      DS_IDLE, DS_RECV: begin
        if (take) begin
          next_st.state = DS_RECV;
          if (st.cnt == 5'h00) begin
            next_st.cmd = link.reqData;
            next_st.sid = link.reqSid;
            next_st.did = link.reqDid;
          end
          // Names are captured; reserved and obsolete words are ignored
          if (st.cnt == fcl_pkg::CHECK_PORT_HI)
            next_st.port[63:32] = link.reqData;
          if (st.cnt == fcl_pkg::CHECK_PORT_LO)
            next_st.port[31:0] = link.reqData;
          if (st.cnt == fcl_pkg::CHECK_SWITCH_HI)
            next_st.sw[63:32] = link.reqData;
          if (st.cnt == fcl_pkg::CHECK_SWITCH_LO)
            next_st.sw[31:0] = link.reqData;
          // Addressing must stay valid for every word of the frame
          if (isCommit) begin
            next_st.addrOk = addrNow
                && fcl_pkg::fcl_is_domain_ctrl(link.reqSid)
                && fcl_pkg::fcl_is_domain_ctrl(link.reqDid);
          end else begin
            next_st.addrOk = addrNow
                && link.reqSid == fcl_pkg::FABRIC_CTRL_ID
                && link.reqDid == fcl_pkg::FABRIC_CTRL_ID;
          end
          if (st.cnt != 5'h1F) next_st.cnt = words;
          if (link.reqLast) begin
            okCommit = isCommit && next_st.addrOk && commitEnable
                       && words == fcl_pkg::COMMIT_REQ_WORDS;
            okCheck  = isCheck && next_st.addrOk && checkEnable
                       && words == fcl_pkg::CHECK_WORDS;
            next_st.state   = DS_SEND;
            next_st.rqReady = 1'b0;
            next_st.cnt     = 5'h00;
            next_st.idx     = 5'h00;
            next_st.valid   = 1'b1;
            next_st.last    = 1'b0;
            next_st.sid     = link.reqDid;
            next_st.did     = st.cnt == 5'h00 ? link.reqSid : st.sid;
            if (st.cnt == 5'h00) next_st.sid = link.reqDid;
            else next_st.sid = st.did;
            if (okCommit) begin
              next_st.kind    = fcl_pkg::FR_ACCEPT;
              next_st.lead    = fcl_pkg::ACCEPT_WORD;
              next_st.policy  = st.pending;
              next_st.applied = 1'b1;
            end else if (okCheck) begin
              next_st.kind     = fcl_pkg::FR_CHECK;
              next_st.lead     = fcl_pkg::ACCEPT_WORD;
              next_st.peerPort = next_st.port;
              next_st.peerSw   = next_st.sw;
              next_st.checked  = 1'b1;
            end else begin
              next_st.kind = fcl_pkg::FR_REJECT;
              next_st.lead = fcl_pkg::REJECT_WORD;
            end
            next_st.data = next_st.lead;
          end
        end
      end
      DS_SEND: begin
        if (link.rspReady) begin
          if (st.last) begin
            next_st.state   = DS_IDLE;
            next_st.valid   = 1'b0;
            next_st.last    = 1'b0;
            next_st.rqReady = 1'b1;
          end else begin
            // Responder's own parameters fill the accept fields
            next_st.idx  = st.idx + 5'h01;
            next_st.data = fcl_pkg::fcl_frame_word(st.kind, st.lead,
                localParams, st.idx + 5'h01);
            next_st.last = (st.idx + 5'h02) ==
                fcl_pkg::fcl_frame_len(st.kind);
          end
        end
      end
      default: begin
        next_st.state   = DS_IDLE;
        next_st.rqReady = 1'b1;
      end
    endcase
  end

  // State register; reset already loads ready high, so words are taken from the first edge after reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st         <= '0;
      st.state   <= DS_IDLE;
      st.rqReady <= 1'b1;
      st.policy  <= fcl_pkg::POLICY_RESET;
      st.pending <= fcl_pkg::POLICY_RESET;
      st.allow   <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Reply addressing is the request's, swapped
  assign link.reqReady  = st.rqReady;
  assign link.rspData   = st.data;
  assign link.rspValid  = st.valid;
  assign link.rspLast   = st.last;
  assign link.rspSid    = st.sid;
  assign link.rspDid    = st.did;
  assign activePolicy   = st.policy;
  assign strictMerge    = st.policy[fcl_pkg::STRICT_MERGE_BIT];
  assign blockDefaultZone = st.policy[fcl_pkg::DEFAULT_ZONE_BIT];
  assign joinAdmit      = st.admit;
  assign trafficAllow   = st.allow;
  assign commitApplied  = st.applied;
  assign checkAccepted  = st.checked;
  assign peerPortName   = st.peerPort;
  assign peerSwitchName = st.peerSw;

endmodule : fcl_device_end

//--- core/fcl_pkg.sv
// Constants, types and frame helpers for the fabric config link framers.
// Assumes both ends share core_clk and see whole 32-bit payload words.
package fcl_pkg;

  localparam int          WORD_W = 32;
  localparam int          ID_W   = 24;
  localparam int          CNT_W  = 5;

  // Leading command words and the reject reason word
  localparam logic [31:0] COMMIT_REQ_WORD = 32'h0260_0000;
  localparam logic [31:0] CHECK_REQ_WORD  = 32'h2900_0000;
  localparam logic [31:0] ACCEPT_WORD     = 32'h0200_0000;
  localparam logic [31:0] REJECT_WORD     = 32'h0100_0000;
  localparam logic [31:0] REJECT_REASON   = 32'h0000_0000;

  // Addressing
  localparam logic [15:0] DOMAIN_CTRL_PREFIX = 16'hFFFC;
  localparam logic [23:0] FABRIC_CTRL_ID     = 24'h0F_FFFD;

  // Frame lengths in words
  localparam logic [4:0]  COMMIT_REQ_WORDS = 5'h01;
  localparam logic [4:0]  COMMIT_ACC_WORDS = 5'h02;
  localparam logic [4:0]  CHECK_WORDS      = 5'h14;
  localparam logic [4:0]  REJECT_WORDS     = 5'h02;

  // Word positions inside a connectivity check frame
  localparam logic [4:0]  CHECK_PORT_HI   = 5'h04;
  localparam logic [4:0]  CHECK_PORT_LO   = 5'h05;
  localparam logic [4:0]  CHECK_SWITCH_HI = 5'h06;
  localparam logic [4:0]  CHECK_SWITCH_LO = 5'h07;

  // Zoning policy flags word
  localparam int          STRICT_MERGE_BIT = 2;
  localparam int          DEFAULT_ZONE_BIT = 3;
  localparam logic [31:0] POLICY_USED_MASK = 32'h0000_000C;
  localparam logic [31:0] POLICY_RESET     = 32'h0000_0000;

  typedef enum logic [1:0] {
    FR_COMMIT = 2'h0,
    FR_CHECK  = 2'h1,
    FR_REJECT = 2'h2,
    FR_ACCEPT = 2'h3
  } fcl_frame_type;

  typedef struct packed {
    logic [7:0]   revision;
    logic [15:0]  flags;
    logic [31:0]  resAllocTimeout;
    logic [31:0]  errDetectTimeout;
    logic [63:0]  portName;
    logic [63:0]  switchName;
    logic [127:0] serviceParams;
    logic [31:0]  class2Params;
    logic [31:0]  class3Params;
  } fcl_link_params_type;

  // Reserved policy bits are forced to zero
  function automatic logic [31:0] fcl_policy_clean(logic [31:0] w);
    return w & POLICY_USED_MASK;
  endfunction : fcl_policy_clean

  function automatic logic fcl_is_domain_ctrl(logic [23:0] id);
    return id[23:8] == DOMAIN_CTRL_PREFIX;
  endfunction : fcl_is_domain_ctrl

  function automatic logic [4:0] fcl_frame_len(fcl_frame_type k);
    case (k)
      FR_COMMIT: return COMMIT_REQ_WORDS;
      FR_CHECK:  return CHECK_WORDS;
      FR_REJECT: return REJECT_WORDS;
      default:   return COMMIT_ACC_WORDS;
    endcase
  endfunction : fcl_frame_len

  // Word idx of any frame; reserved and obsolete positions send zero
  function automatic logic [31:0] fcl_frame_word(fcl_frame_type k,
      logic [31:0] lead, fcl_link_params_type p, logic [4:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (idx == 5'h00) begin
      w = lead;
    end else if (k == FR_REJECT) begin
      w = REJECT_REASON;
    end else if (k == FR_CHECK) begin
      case (idx)
        5'h01:   w = {p.revision, p.flags, 8'h00};
        5'h02:   w = p.resAllocTimeout;
        5'h03:   w = p.errDetectTimeout;
        5'h04:   w = p.portName[63:32];
        5'h05:   w = p.portName[31:0];
        5'h06:   w = p.switchName[63:32];
        5'h07:   w = p.switchName[31:0];
        5'h08:   w = p.serviceParams[127:96];
        5'h09:   w = p.serviceParams[95:64];
        5'h0A:   w = p.serviceParams[63:32];
        5'h0B:   w = p.serviceParams[31:0];
        5'h0D:   w = p.class2Params;
        5'h0E:   w = p.class3Params;
        default: w = 32'h0000_0000;
      endcase
    end
    return w;
  endfunction : fcl_frame_word

endpackage : fcl_pkg

//--- core/fcl_link_if.sv
// Word-stream link between the requesting and the responding switch.
// Assumes both ends run on the same core_clk; ready/valid per word.
`timescale 1ns/1ns
interface fcl_link_if;
  logic [31:0] reqData;
  logic        reqValid;
  logic        reqLast;
  logic        reqReady;
  logic [23:0] reqSid;
  logic [23:0] reqDid;
  logic [31:0] rspData;
  logic        rspValid;
  logic        rspLast;
  logic        rspReady;
  logic [23:0] rspSid;
  logic [23:0] rspDid;

  modport dev_mp (
    input  reqData, reqValid, reqLast, reqSid, reqDid, rspReady,
    output reqReady, rspData, rspValid, rspLast, rspSid, rspDid
  );

  modport host_mp (
    output reqData, reqValid, reqLast, reqSid, reqDid, rspReady,
    input  reqReady, rspData, rspValid, rspLast, rspSid, rspDid
  );
endinterface : fcl_link_if

//--- core/fcl_host_end.sv
// Requesting (managing) switch end: sends commit and connectivity checks.
// Assumes the responder answers every request frame with one reply frame.
`timescale 1ns/1ns
module fcl_host_end (
  input  wire logic                        core_clk,
  input  wire logic                        reset_n,
  fcl_link_if.host_mp                      link,
  input  wire logic                        sendCommit,
  input  wire logic                        sendCheck,
  input  wire logic [7:0]                  srcDomain,
  input  wire logic [7:0]                  dstDomain,
  input  wire fcl_pkg::fcl_link_params_type localParams,
  output logic                             busy,
  output logic                             replyDone,
  output logic                             replyAccepted,
  output logic [63:0]                      peerPortName,
  output logic [63:0]                      peerSwitchName
);

  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SEND = 3'b010,
    HS_WAIT = 3'b100
  } fcl_host_state_type;

  typedef struct packed {
    fcl_host_state_type    state;
    fcl_pkg::fcl_frame_type kind;
    logic [4:0]            idx;
    logic [31:0]           data;
    logic                  valid;
    logic                  last;
    logic [23:0]           sid;
    logic [23:0]           did;
    logic                  rReady;
    logic [31:0]           lead;
    logic [4:0]            rCnt;
    logic                  done;
    logic                  accepted;
    logic [63:0]           port;
    logic [63:0]           sw;
  } fcl_host_reg_type;

  fcl_host_reg_type st;
  fcl_host_reg_type next_st;

  // Next state: transmit one frame, then collect the reply
  always_comb begin
    logic [31:0] lw;
    lw = 32'h0000_0000;
    next_st = st;
    next_st.done = 1'b0;
    case (st.state)
      HS_IDLE: begin
        if (sendCommit || sendCheck) begin
          next_st.state = HS_SEND;
          next_st.kind  = sendCommit ? fcl_pkg::FR_COMMIT : fcl_pkg::FR_CHECK;
          lw = sendCommit ? fcl_pkg::COMMIT_REQ_WORD
                          : fcl_pkg::CHECK_REQ_WORD;
          next_st.idx   = 5'h00;
          next_st.data  = lw;
          next_st.valid = 1'b1;
          next_st.last  = sendCommit;
          if (sendCommit) begin
            next_st.sid = {fcl_pkg::DOMAIN_CTRL_PREFIX, srcDomain};
            next_st.did = {fcl_pkg::DOMAIN_CTRL_PREFIX, dstDomain};
          end else begin
            next_st.sid = fcl_pkg::FABRIC_CTRL_ID;
            next_st.did = fcl_pkg::FABRIC_CTRL_ID;
          end
        end
      end
      HS_SEND: begin
        if (link.reqReady) begin
          if (st.last) begin
            next_st.state  = HS_WAIT;
            next_st.valid  = 1'b0;
            next_st.last   = 1'b0;
            next_st.rReady = 1'b1;
            next_st.rCnt   = 5'h00;
          end else begin
            next_st.idx  = st.idx + 5'h01;
            next_st.data = fcl_pkg::fcl_frame_word(st.kind,
                fcl_pkg::CHECK_REQ_WORD, localParams, st.idx + 5'h01);
            next_st.last = (st.idx + 5'h02) ==
                fcl_pkg::fcl_frame_len(st.kind);
          end
        end
      end
      HS_WAIT: begin
        if (link.rspValid) begin
          if (st.rCnt == 5'h00) next_st.lead = link.rspData;
          if (st.rCnt == fcl_pkg::CHECK_PORT_HI)
            next_st.port[63:32] = link.rspData;
          if (st.rCnt == fcl_pkg::CHECK_PORT_LO)
            next_st.port[31:0] = link.rspData;
          if (st.rCnt == fcl_pkg::CHECK_SWITCH_HI)
            next_st.sw[63:32] = link.rspData;
          if (st.rCnt == fcl_pkg::CHECK_SWITCH_LO)
            next_st.sw[31:0] = link.rspData;
          if (st.rCnt != 5'h1F) next_st.rCnt = st.rCnt + 5'h01;
          if (link.rspLast) begin
            next_st.state    = HS_IDLE;
            next_st.rReady   = 1'b0;
            next_st.done     = 1'b1;
            // Accept only with the right lead word and length
            next_st.accepted = ((st.rCnt == 5'h00) ? link.rspData : st.lead)
                == fcl_pkg::ACCEPT_WORD &&
                (st.rCnt + 5'h01) == ((st.kind == fcl_pkg::FR_CHECK)
                ? fcl_pkg::CHECK_WORDS : fcl_pkg::COMMIT_ACC_WORDS);
          end
        end
      end
      default: next_st.state = HS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st       <= '0;
      st.state <= HS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign link.reqData  = st.data;
  assign link.reqValid = st.valid;
  assign link.reqLast  = st.last;
  assign link.reqSid   = st.sid;
  assign link.reqDid   = st.did;
  assign link.rspReady = st.rReady;
  assign busy          = st.state != HS_IDLE;
  assign replyDone     = st.done;
  assign replyAccepted = st.accepted;
  assign peerPortName  = st.port;
  assign peerSwitchName = st.sw;

endmodule : fcl_host_end

//--- testbench/fcl_link_properties.sv
// Checker for the word link between the host end and the device end.
// Assumes it sits on the one link where both parties are design ends.
`timescale 1ns/1ns
module fcl_link_properties (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [31:0] reqData,
  input wire logic        reqValid,
  input wire logic        reqLast,
  input wire logic        reqReady,
  input wire logic [23:0] reqSid,
  input wire logic [23:0] reqDid,
  input wire logic [31:0] rspData,
  input wire logic        rspValid,
  input wire logic        rspLast,
  input wire logic        rspReady,
  input wire logic [23:0] rspSid,
  input wire logic [23:0] rspDid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Every request frame gets a reply starting one cycle later
  reply_start_a : assert property (
    reqValid && reqReady && reqLast |=> rspValid)
    else $error("reply did not start");
  // No new request words while a reply is in flight
  ready_low_a : assert property (
    rspValid |-> !reqReady)
    else $error("request taken during reply");
  // Reply opens with accept or reject only
  reply_lead_a : assert property (
    $rose(rspValid) |-> rspData == fcl_pkg::ACCEPT_WORD ||
      rspData == fcl_pkg::REJECT_WORD)
    else $error("bad reply lead word");
  // Reply addressing is the request addressing turned round
  ids_swapped_a : assert property (
    $rose(rspValid) |-> rspSid == $past(reqDid) && rspDid == $past(reqSid))
    else $error("reply ids not swapped");
  // Last reply word is reserved, obsolete or the reject reason, always sent as zero
  last_word_zero_a : assert property (
    rspValid && rspLast |-> rspData == 32'h0000_0000)
    else $error("last reply word not zero");
  // Reply words follow back to back until the last one is taken
  reply_hold_a : assert property (
    rspValid && !(rspReady && rspLast) |=> rspValid)
    else $error("reply word dropped");
  // Reply is finite and short
  reply_bound_a : assert property (
    $rose(rspValid) |-> ##[0:63] (rspValid && rspReady && rspLast))
    else $error("reply did not end");
  // Link reopens right after the reply ends
  link_reopen_a : assert property (
    rspValid && rspReady && rspLast |=> !rspValid && reqReady)
    else $error("link did not reopen");
  // Commit requests use domain controller ids
  commit_ids_a : assert property (
    reqValid && reqData == fcl_pkg::COMMIT_REQ_WORD |->
      reqSid[23:8] == 16'hFFFC && reqDid[23:8] == 16'hFFFC)
    else $error("commit ids wrong");
  // Check requests use fabric controller ids
  check_ids_a : assert property (
    reqValid && reqData == fcl_pkg::CHECK_REQ_WORD |->
      reqSid == fcl_pkg::FABRIC_CTRL_ID && reqDid == fcl_pkg::FABRIC_CTRL_ID)
    else $error("check ids wrong");
endmodule : fcl_link_properties

//--- testbench/tb.sv
// Bench: host end and device end on one link, plus a second device
// fed directly with one valid commit and then frames that break the request rules.
// Assumes 50 MHz core_clk and inputs driven 2 ns after each edge.
`timescale 1ns/1ns
module tb;
  logic        core_clk, reset_n, sendCommit, sendCheck, policyLoad;
  logic        commitEnable, checkEnable, dbEqual, dbMergeable;
  logic        bothDefaultZone, busy, replyDone, replyAccepted;
  logic        strictMerge, blockDefaultZone, joinAdmit, trafficAllow;
  logic [31:0] policyWord, activePolicy, lead;
  logic [63:0] hPort, hSwitch, dPort, dSwitch;
  logic        commitApplied, checkAccepted;
  int          errTotal, testsRun, appliedCount, checkedCount;
  fcl_pkg::fcl_link_params_type hostParams, devParams;
  fcl_link_if lnk();
  fcl_link_if bad();

  fcl_host_end i_fcl_host_end (.core_clk, .reset_n, .link(lnk),
    .sendCommit, .sendCheck, .srcDomain(8'h01), .dstDomain(8'h02),
    .localParams(hostParams), .busy, .replyDone, .replyAccepted,
    .peerPortName(hPort), .peerSwitchName(hSwitch));
  fcl_device_end i_fcl_device_end (.core_clk, .reset_n, .link(lnk),
    .policyLoad, .policyWord, .commitEnable, .checkEnable,
    .localParams(devParams), .dbEqual, .dbMergeable, .bothDefaultZone,
    .activePolicy, .strictMerge, .blockDefaultZone, .joinAdmit,
    .trafficAllow, .commitApplied, .checkAccepted,
    .peerPortName(dPort), .peerSwitchName(dSwitch));
  // Second device sees only bench-made frames; its outputs are unused
  fcl_device_end i_fcl_device_end_bad (.core_clk, .reset_n, .link(bad),
    .policyLoad, .policyWord, .commitEnable, .checkEnable,
    .localParams(devParams), .dbEqual, .dbMergeable, .bothDefaultZone,
    .activePolicy(), .strictMerge(), .blockDefaultZone(), .joinAdmit(),
    .trafficAllow(), .commitApplied(), .checkAccepted(),
    .peerPortName(), .peerSwitchName());
  fcl_link_properties i_fcl_link_properties (.core_clk, .reset_n,
    .reqData(lnk.reqData), .reqValid(lnk.reqValid),
    .reqLast(lnk.reqLast), .reqReady(lnk.reqReady), .reqSid(lnk.reqSid),
    .reqDid(lnk.reqDid), .rspData(lnk.rspData), .rspValid(lnk.rspValid),
    .rspLast(lnk.rspLast), .rspReady(lnk.rspReady), .rspSid(lnk.rspSid),
    .rspDid(lnk.rspDid));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic closeOut();
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : closeOut

  // Hang guard: whole run is well under a thousand cycles
  initial begin
    #200000;
    errTotal++;
    closeOut();
  end

  // Pulses are counted, since they are over before a request returns
  always @(posedge core_clk) begin
    appliedCount <= appliedCount + int'(commitApplied === 1'b1);
    checkedCount <= checkedCount + int'(checkAccepted === 1'b1);
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  task automatic load(input logic [31:0] w);
    policyLoad = 1'b1;
    policyWord = w;
    tick(1);
    policyLoad = 1'b0;
    tick(1);
  endtask : load

  // One host request; waits for the reply under a bounded count
  task automatic req(input logic commit);
    sendCommit = commit;
    sendCheck  = !commit;
    tick(1);
    sendCommit = 1'b0;
    sendCheck  = 1'b0;
    chk(busy, 1'b1);
    for (int n = 0; n < 200 && replyDone !== 1'b1; n++) tick(1);
    chk(replyDone, 1'b1);
    chk(busy, 1'b0);
  endtask : req

  // Raw frame on the second link; lead word of the reply comes back
  task automatic raw(input logic [23:0] sid, input logic [23:0] did,
      input logic [31:0] w0, input int n, output logic [31:0] got);
    logic ok;
    bad.reqSid = sid;
    bad.reqDid = did;
    for (int i = 0; i < n; i++) begin
      bad.reqData  = (i == 0) ? w0 : 32'h0000_0000;
      bad.reqLast  = (i == n - 1);
      bad.reqValid = 1'b1;
      do begin
        ok = bad.reqReady;
        tick(1);
      end while (!ok);
    end
    bad.reqValid = 1'b0;
    bad.reqLast  = 1'b0;
    bad.reqData  = ~bad.reqData; // Released data must not look valid
    for (int k = 0; k < 50 && bad.rspValid !== 1'b1; k++) tick(1);
    got = bad.rspData;
    tick(4);
  endtask : raw

  initial begin
    {sendCommit, sendCheck, policyLoad, dbEqual, dbMergeable} = 5'h00;
    {commitEnable, checkEnable, bothDefaultZone} = 3'h7;
    policyWord = 32'h0000_0000;
    errTotal   = 0;
    testsRun   = 0;
    hostParams = {8'h01, 16'h0203, 32'h7D0, 32'h3E8, 64'h1111_2222_3333_4444,
                  64'h5555_6666_7777_8888, 128'h9, 32'hA, 32'hB};
    devParams  = {8'h01, 16'h0405, 32'h7D0, 32'h3E8, 64'hAAAA_BBBB_CCCC_DDDD,
                  64'hEEEE_0101_0202_0303, 128'hC, 32'hD, 32'hE};
    {bad.reqValid, bad.reqLast, bad.reqData} = 34'h0_0000_0000;
    {bad.reqSid, bad.reqDid} = 48'h0000_0000_0000;
    bad.rspReady = 1'b1;
    reset_n = 1'b0;
    tick(4);
    reset_n = 1'b1;
    chk(activePolicy, 32'h0000_0000);
    chk(trafficAllow, 1'b1);
    // Strict merge, default zone open; reserved bits must drop
    load(32'hFFFF_FFF7);
    req(1'b1);
    chk(replyAccepted, 1'b1);
    chk(activePolicy, 32'h0000_0004);
    chk(strictMerge, 1'b1);
    dbMergeable = 1'b1;
    tick(2);
    chk(joinAdmit, 1'b0);
    dbEqual = 1'b1;
    tick(2);
    chk(joinAdmit, 1'b1);
    chk(trafficAllow, 1'b1);
    chk(blockDefaultZone, 1'b0);
    $display("test strict policy done");
    // Permissive merge, default zone blocked
    load(32'h0000_0008);
    req(1'b1);
    chk(activePolicy, 32'h0000_0008);
    dbEqual = 1'b0;
    tick(2);
    chk(joinAdmit, 1'b1);
    chk(trafficAllow, 1'b0);
    chk(blockDefaultZone, 1'b1);
    dbMergeable = 1'b0;
    tick(2);
    chk(joinAdmit, 1'b0);
    $display("test permissive policy done");
    // Refused commit leaves the policy alone
    commitEnable = 1'b0;
    load(32'h0000_0004);
    req(1'b1);
    chk(replyAccepted, 1'b0);
    chk(activePolicy, 32'h0000_0008);
    commitEnable = 1'b1;
    $display("test commit reject done");
    // Connectivity check both ways, then refused
    req(1'b0);
    chk(replyAccepted, 1'b1);
    chk(hPort, devParams.portName);
    chk(hSwitch, devParams.switchName);
    chk(dPort, hostParams.portName);
    chk(dSwitch, hostParams.switchName);
    checkEnable = 1'b0;
    req(1'b0);
    chk(replyAccepted, 1'b0);
    checkEnable = 1'b1;
    chk(appliedCount, 2);
    chk(checkedCount, 1);
    $display("test connectivity check done");
    // One good commit, then frames from a misbehaving requester on the second link
    raw(24'hFFFC01, 24'hFFFC02, fcl_pkg::COMMIT_REQ_WORD, 1, lead);
    chk(lead, fcl_pkg::ACCEPT_WORD);
    raw(24'h123401, 24'hFFFC02, fcl_pkg::COMMIT_REQ_WORD, 1, lead);
    chk(lead, fcl_pkg::REJECT_WORD);
    raw(24'hFFFC01, 24'hFFFC02, fcl_pkg::COMMIT_REQ_WORD, 2, lead);
    chk(lead, fcl_pkg::REJECT_WORD);
    raw(24'hFFFC01, 24'hFFFC02, fcl_pkg::CHECK_REQ_WORD, 20, lead);
    chk(lead, fcl_pkg::REJECT_WORD);
    $display("test bad frames done");
    closeOut();
  end
endmodule : tb
